// >>> rtl/adcf_defines.vh
// Overview of operation
// - acquisition lasts 6, 10, 18 or 34 clocks
// - powerdown accepted at any moment
// - powerdown mid-conversion aborts, leaves invalid data
// - 17-bit MSB: don't-cares, sign, MSB..LSB
// - 13-bit MSB: sign, then MSB..LSB
// - 13-bit LSB: LSB..MSB, sign last
// - 16-bit unsigned: four zeros, MSB..LSB
// - 12-bit unsigned: twelve bits MSB..LSB
// - don't-care bits any level, host ignores
// - four address bits select pair or single
// - positive to first output, negative second
`ifndef ADCF_DEFINES_VH
`define ADCF_DEFINES_VH
`define ADCF_FMT_17M 3'h0
`define ADCF_FMT_13M 3'h1
`define ADCF_FMT_17L 3'h2
`define ADCF_FMT_13L 3'h3
`define ADCF_FMT_16M 3'h4
`define ADCF_FMT_12M 3'h5
`define ADCF_FMT_16L 3'h6
`define ADCF_FMT_12L 3'h7
`define ADCF_ACQ_6 2'h0
`define ADCF_ACQ_10 2'h1
`define ADCF_ACQ_18 2'h2
`define ADCF_ACQ_34 2'h3
`define ADCF_ACQ_LEN_6 6'h06
`define ADCF_ACQ_LEN_10 6'h0a
`define ADCF_ACQ_LEN_18 6'h12
`define ADCF_ACQ_LEN_34 6'h22
`define ADCF_COM_SEL 4'h8
`define ADCF_ADDR_BITS 4
`define ADCF_CONV_CLOCKS 6'h2c
`endif

// >>> rtl/adcf_top.v
`timescale 1ns/1ps
`default_nettype none
`include "adcf_defines.vh"
module adcf_top
(
	input wire CLOCK,
	input wire RESET_N,
	input wire SERIAL_CLOCK,
	input wire SERIAL_DATA_IN,
	input wire CHIP_SELECT_N,
	input wire CONVERSION_CLOCK,
	input wire POWERDOWN_REQUEST,
	input wire [2:0] FORMAT_SELECT,
	input wire [1:0] ACQ_SELECT,
	input wire [12:0] RESULT_VALUE,
	output reg SERIAL_DATA_OUT,
	output reg [3:0] MUX_POSITIVE_OUTPUT,
	output reg [3:0] MUX_NEGATIVE_OUTPUT,
	output reg ACQUIRING,
	output reg CONVERTING,
	output reg RESULT_VALID
);
	localparam ST_IDLE = 3'h1;
	localparam ST_ACQ = 3'h2;
	localparam ST_CONV = 3'h4;

	// two-flop synchronisers; first stage read only by second
	reg [3:0] s1_reg;
	reg [3:0] s2_reg;
	reg [1:0] edge_hist_reg;
	reg sdi_reg;
	always @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			// chip select rests high, so reset must not fake a selected frame
			s1_reg <= 4'h1;
			s2_reg <= 4'h1;
			edge_hist_reg <= 2'h0;
			sdi_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= {SERIAL_CLOCK, CONVERSION_CLOCK, POWERDOWN_REQUEST, CHIP_SELECT_N};
			s2_reg <= s1_reg;
			edge_hist_reg <= {s2_reg[3], s2_reg[2]};
			sdi_reg <= SERIAL_DATA_IN;
		end
	end
	reg sdi_s1_reg;
	reg sdi_s2_reg;
	always @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			sdi_s1_reg <= 1'b0;
			sdi_s2_reg <= 1'b0;
		end
		else
		begin
			sdi_s1_reg <= sdi_reg;
			sdi_s2_reg <= sdi_s1_reg;
		end
	end
	wire sclk_rise = s2_reg[3] & ~edge_hist_reg[1];
	wire sclk_fall = ~s2_reg[3] & edge_hist_reg[1];
	wire conversion_clock_rise = s2_reg[2] & ~edge_hist_reg[0];
	wire pd = s2_reg[1];
	wire cs_n = s2_reg[0];
	// data pin gets an extra flop so it lines up with the serial clock path
	wire sdi = sdi_s2_reg;

	// acquisition length: data clock periods, same source assumed
	reg [5:0] acq_len;
	always @*
	begin
		case (ACQ_SELECT)
			`ADCF_ACQ_6: acq_len = `ADCF_ACQ_LEN_6;
			`ADCF_ACQ_10: acq_len = `ADCF_ACQ_LEN_10;
			`ADCF_ACQ_18: acq_len = `ADCF_ACQ_LEN_18;
			default: acq_len = `ADCF_ACQ_LEN_34;
		endcase
	end

	reg [2:0] state_reg;
	reg [5:0] count_reg;
	reg [2:0] addr_cnt_reg;
	reg [3:0] addr_shift_reg;
	reg [3:0] addr_reg;
	reg [16:0] out_word_reg;
	reg [4:0] out_len_reg;
	reg [4:0] out_idx_reg;

	// word builder: returns bits in shift order, index 16 first
	function [16:0] build;
		input [2:0] fmt;
		input [12:0] r;
		integer i;
		reg [11:0] rev;
		begin
			for (i = 0; i < 12; i = i + 1)
				rev[i] = r[11 - i];
			case (fmt)
				`ADCF_FMT_17M: build = {4'h0, r[12], r[11:0]};
				`ADCF_FMT_13M: build = {r[12], r[11:0], 4'h0};
				`ADCF_FMT_17L: build = {rev, 4'h0, r[12]};
				`ADCF_FMT_13L: build = {rev, r[12], 4'h0};
				`ADCF_FMT_16M: build = {4'h0, r[11:0], 1'b0};
				`ADCF_FMT_12M: build = {r[11:0], 5'h00};
				`ADCF_FMT_16L: build = {rev, 4'h0, 1'b0};
				default: build = {rev, 5'h00};
			endcase
		end
	endfunction

	function [4:0] fmt_len;
		input [2:0] fmt;
		begin
			case (fmt)
				`ADCF_FMT_17M, `ADCF_FMT_17L: fmt_len = 5'h11;
				`ADCF_FMT_13M, `ADCF_FMT_13L: fmt_len = 5'h0d;
				`ADCF_FMT_16M, `ADCF_FMT_16L: fmt_len = 5'h10;
				default: fmt_len = 5'h0c;
			endcase
		end
	endfunction

	// conversion sequencer; powerdown overrides any state
	always @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			state_reg <= ST_IDLE;
			count_reg <= 6'h00;
			addr_cnt_reg <= 3'h0;
			addr_shift_reg <= 4'h0;
			addr_reg <= 4'h0;
			out_word_reg <= 17'h00000;
			out_len_reg <= 5'h00;
			RESULT_VALID <= 1'b0;
		end
		else if (pd)
		begin
			// abort; if caught mid-conversion, the word left in the shifter is spoiled so it cannot pass as a result
			state_reg <= ST_IDLE;
			count_reg <= 6'h00;
			addr_cnt_reg <= 3'h0;
			if (state_reg == ST_CONV)
			begin
				RESULT_VALID <= 1'b0;
				out_word_reg <= ~out_word_reg;
			end
		end
		else
		begin
			if (cs_n)
				addr_cnt_reg <= 3'h0;
			else if (sclk_rise && addr_cnt_reg < 3'h4)
			begin
				addr_shift_reg <= {addr_shift_reg[2:0], sdi};
				addr_cnt_reg <= addr_cnt_reg + 3'h1;
			end
			case (state_reg)
				ST_IDLE:
				begin
					if (!cs_n && sclk_rise && addr_cnt_reg == 3'h4)
					begin
						// address latched only as acquisition starts
						addr_reg <= addr_shift_reg;
						state_reg <= ST_ACQ;
						count_reg <= 6'h00;
					end
				end
				ST_ACQ:
				begin
					if (sclk_rise)
					begin
						if (count_reg == acq_len - 6'h01)
						begin
							state_reg <= ST_CONV;
							count_reg <= 6'h00;
						end
						else
							count_reg <= count_reg + 6'h01;
					end
				end
				ST_CONV:
				begin
					if (conversion_clock_rise)
					begin
						if (count_reg == `ADCF_CONV_CLOCKS - 6'h01)
						begin
							out_word_reg <= build(FORMAT_SELECT, RESULT_VALUE);
							out_len_reg <= fmt_len(FORMAT_SELECT);
							RESULT_VALID <= 1'b1;
							state_reg <= ST_IDLE;
						end
						else
							count_reg <= count_reg + 6'h01;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// output shifter: starts at bit 16 each frame, changes on falling edge
	always @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			out_idx_reg <= 5'h10;
			SERIAL_DATA_OUT <= 1'b0;
		end
		else if (cs_n)
		begin
			out_idx_reg <= 5'h10;
			SERIAL_DATA_OUT <= out_word_reg[16];
		end
		else if (sclk_fall && out_idx_reg != 5'h00)
		begin
			// bits past the word's length read zero, except for 17-bit words, whose bit 0 holds to the end of a long frame
			out_idx_reg <= out_idx_reg - 5'h01;
			SERIAL_DATA_OUT <= (5'h11 - out_idx_reg < out_len_reg) ? out_word_reg[out_idx_reg - 5'h01] : 1'b0;
		end
	end

	// mux decode: first bit single-ended, second odd channel / polarity, last two the pair
	always @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			MUX_POSITIVE_OUTPUT <= 4'h0;
			MUX_NEGATIVE_OUTPUT <= 4'h1;
			ACQUIRING <= 1'b0;
			CONVERTING <= 1'b0;
		end
		else
		begin
			ACQUIRING <= (state_reg == ST_ACQ) & ~pd;
			CONVERTING <= (state_reg == ST_CONV) & ~pd;
			if (addr_reg[3])
			begin
				// single channel measured against the common return
				MUX_POSITIVE_OUTPUT <= {1'b0, addr_reg[1:0], addr_reg[2]};
				MUX_NEGATIVE_OUTPUT <= `ADCF_COM_SEL;
			end
			else
			begin
				// pair: the odd bit swaps which channel counts as positive
				MUX_POSITIVE_OUTPUT <= {1'b0, addr_reg[1:0], addr_reg[2]};
				MUX_NEGATIVE_OUTPUT <= {1'b0, addr_reg[1:0], ~addr_reg[2]};
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/adcf_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adcf_top_chk
(
	input wire CLOCK,
	input wire RESET_N,
	input wire SERIAL_CLOCK,
	input wire POWERDOWN_REQUEST,
	input wire [1:0] ACQ_SELECT,
	input wire [3:0] MUX_POSITIVE_OUTPUT,
	input wire [3:0] MUX_NEGATIVE_OUTPUT,
	input wire ACQUIRING,
	input wire CONVERTING,
	input wire RESULT_VALID
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	logic sclk_d;
	logic [5:0] rises;
	// raw link clock rises inside the window; sync delay stays under half a link period
	always @(posedge CLOCK)
	begin
		sclk_d <= SERIAL_CLOCK;
		rises <= ACQUIRING ? rises + {5'h0, SERIAL_CLOCK & ~sclk_d} : 6'h0;
	end
	sequence s_acq_done;
		$fell(ACQUIRING) ##0 CONVERTING;
	endsequence
	sequence s_pd_held;
		POWERDOWN_REQUEST [*5];
	endsequence
	chk_acq_len: assert property (s_acq_done |-> rises == 6'h2 + (6'h4 << ACQ_SELECT))
		else $error("acq len");
	chk_conv_order: assert property ($rose(CONVERTING) |-> $past(ACQUIRING)) else $error("conv order");
	chk_pd_idle: assert property (s_pd_held |-> !ACQUIRING && !CONVERTING) else $error("pd idle");
	chk_pd_abort: assert property (CONVERTING && POWERDOWN_REQUEST |-> ##[1:5] !CONVERTING && !RESULT_VALID)
		else $error("pd abort");
	chk_valid_src: assert property ($rose(RESULT_VALID) |-> $past(CONVERTING)) else $error("valid src");
	chk_mux_pair: assert property (MUX_NEGATIVE_OUTPUT == 4'h8 || MUX_NEGATIVE_OUTPUT == (MUX_POSITIVE_OUTPUT ^ 4'h1))
		else $error("mux pair");
	chk_mux_pos: assert property (MUX_POSITIVE_OUTPUT < 4'h8) else $error("mux pos");
	chk_mux_hold: assert property (!$stable({MUX_POSITIVE_OUTPUT, MUX_NEGATIVE_OUTPUT}) |-> ACQUIRING)
		else $error("mux hold");
endmodule
bind adcf_top adcf_top_chk u_chk (.CLOCK, .RESET_N, .SERIAL_CLOCK, .POWERDOWN_REQUEST, .ACQ_SELECT,
	.MUX_POSITIVE_OUTPUT, .MUX_NEGATIVE_OUTPUT, .ACQUIRING, .CONVERTING, .RESULT_VALID);
`default_nettype wire

// >>> sim/adcf_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcf_host
(
	output logic sclk,
	output logic di,
	output logic cs_n,
	input wire dout
);
	// words are taken as plain results only; test-mode words never stand for accuracy
	logic [16:0] word;
	// link clock stands low between frames
	initial {sclk, di, cs_n} = 3'b001;
	// address bits first, then a toggling filler; each data bit is taken late in its period
	task automatic frame(input logic [3:0] addr, input int n);
		#1 cs_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			di = (i < 4) ? addr[3 - i] : ~di;
			#32 sclk = 1'b1;
			#30 if (i < 17) word[i] = dout;
			#2 sclk = 1'b0;
		end
		#32 cs_n = 1'b1;
		di = ~di;
	endtask
endmodule
`default_nettype wire

// >>> sim/adcf_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module adcf_top_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic conversion_clock = 1'b0;
	logic pd = 1'b0;
	logic [2:0] fmt = 3'h0;
	logic [1:0] acq = 2'h0;
	logic [12:0] res = 13'h0;
	logic [35:0] row;
	logic [16:0] val;
	logic [16:0] care;
	int len;
	int k;
	int err_count = 0;
	int check_count = 0;
	wire sclk, di, cs_n, dout, acqg, conv, valid;
	wire [3:0] mpos, mneg; // board ties these one to one to the converter inputs
	// nibbles: format, window code, address, result, expected positive and negative mux outputs
	logic [35:0] rows [8] = '{36'h0201a5301, 36'h1130c3a67, 36'h2251e8132, 36'h3360b0754,
		36'h428193108, 36'h51b0a6c68, 36'h62d1f0e38, 36'h73e035958};
	adcf_host host (.sclk(sclk), .di(di), .cs_n(cs_n), .dout(dout));
	adcf_top DUT (.CLOCK(clk), .RESET_N(rst_n), .SERIAL_CLOCK(sclk), .SERIAL_DATA_IN(di), .CHIP_SELECT_N(cs_n),
		.CONVERSION_CLOCK(conversion_clock), .POWERDOWN_REQUEST(pd), .FORMAT_SELECT(fmt), .ACQ_SELECT(acq), .RESULT_VALUE(res),
		.SERIAL_DATA_OUT(dout), .MUX_POSITIVE_OUTPUT(mpos), .MUX_NEGATIVE_OUTPUT(mneg), .ACQUIRING(acqg),
		.CONVERTING(conv), .RESULT_VALID(valid));
	initial forever #4 clk = ~clk;
	// offset keeps the conversion clock's edges off the system clock's edges
	initial #2 forever #20 conversion_clock = ~conversion_clock;
	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one frame, then a bounded wait until the conversion is over
	task automatic convert(input logic [3:0] addr, input int n);
		int w;
		host.frame(addr, n);
		for (w = 0; w < 3000 && conv !== 1'b0; w++) @(posedge clk);
		if (w == 3000)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[j])
		begin
			row = rows[j];
			fmt <= row[34:32];
			acq <= row[29:28];
			res <= row[20:8];
			repeat (10) @(posedge clk);
			convert(row[27:24], 7 + (4 << row[29:28]));
			check(mpos === row[7:4] && mneg === row[3:0], "mux select");
			convert(row[27:24], 7 + (4 << row[29:28]));
			len = (fmt[2] ? 16 : 17) - (fmt[0] ? 4 : 0);
			val = fmt[2] ? {5'h0, res[11:0]} : (fmt == 3'h2) ? {res[12], 4'h0, res[11:0]} : {4'h0, res};
			care = (fmt == 3'h0) ? 17'h01fff : (fmt == 3'h2) ? 17'h10fff : 17'h1ffff;
			for (int i = 0; i < len; i++)
			begin
				k = fmt[1] ? i : len - 1 - i;
				if (care[k]) check(host.word[i] === val[k], "data bit");
			end
			$display("row %0d done", j);
		end
		acq <= 2'h0;
		@(posedge clk);
		convert(4'h9, 11);
		check(mpos === 4'h2 && mneg === 4'h8, "single select");
		host.frame(4'h2, 11);
		@(posedge clk);
		pd <= 1'b1;
		repeat (8) @(posedge clk);
		check(valid === 1'b0 && conv === 1'b0, "abort");
		pd <= 1'b0;
		repeat (10) @(posedge clk);
		convert(4'h2, 11); // aborted word shifted out but never checked
		check(valid === 1'b1 && mpos === 4'h4, "recovery");
		$display("powerdown test done");
		// mid-run reset: outputs back to idle, then one more frame
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		check(mpos === 4'h0 && mneg === 4'h1 && acqg === 1'b0 && conv === 1'b0 && valid === 1'b0, "reset");
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		convert(4'h1, 11);
		check(mpos === 4'h2 && mneg === 4'h3 && valid === 1'b1, "after reset");
		$display("reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
